//--- logic/mfib_top.sv
// multifunction interrupt flag bank: three flag/enable registers, request outputs, wake-up
// assumes: event inputs are single-cycle or level pulses from other clock domains,
// software on a plain strobe port with read data one cycle after the read strobe
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "mfib_regs.svh"

// Notes on behaviour
// R01: register 0 bit 5 is timer A compare-A request flag, read/write.
// R02: register 0 bit 4 is timer A compare-P request flag, read/write.
// R03: register 0 bit 1 enables compare-A, bit 0 enables compare-P of timer A.
// R04: register 1 bit 6 is serial port A request flag, read/write.
// R05: register 1 bit 2 enables serial port A request.
// R06: register 1 bit 5 is timer B compare-A request flag.
// R07: register 1 bit 4 is timer B compare-P request flag.
// R08: register 1 bit 1 enables timer B compare-A request.
// R09: register 1 bit 0 enables timer B compare-P request.
// R10: register 2 bit 6 is serial port B request flag.
// R11: register 2 bit 2 enables serial port B request.
// R12: register 2 bit 5 is periodic timer C compare-A request flag.
// R13: register 2 bit 4 is periodic timer C compare-P request flag.
// R14: register 2 bit 1 enables timer C compare-A request.
// R15: register 2 bit 0 enables timer C compare-P request.
// R16: unimplemented bits read zero and ignore writes.
// R17: source event sets its flag regardless of enable.
// R18: request forwarded only with enable set, and only with global enable; here global_irq_en gates only mf_irq, not the mf_req outputs.
// R19: any flag becoming set wakes from sleep or idle.
// R20: each register requests while any enabled flag is set.
module mfib_top
	import mfib_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire mfib_pkg::mfib_addr_t reg_addr,
	input  wire mfib_pkg::mfib_byte_t reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output mfib_pkg::mfib_byte_t reg_rdata,
	input  wire logic       global_irq_en,
	input  wire logic       tmr_a_cmpa_evt,
	input  wire logic       tmr_a_cmpp_evt,
	input  wire logic       tmr_b_cmpa_evt,
	input  wire logic       tmr_b_cmpp_evt,
	input  wire logic       tmr_c_cmpa_evt,
	input  wire logic       tmr_c_cmpp_evt,
	input  wire logic       serial_a_evt,
	input  wire logic       serial_b_evt,
	input  wire logic       sleep_req,
	output logic [2:0]      mf_req,
	output logic            mf_irq,
	output logic            wake
);
	// ----------------------------------------------------------------
	// event synchronisation and edge detect
	// ----------------------------------------------------------------
	localparam int NEVT = 8;

	logic [NEVT-1:0] evt_raw;
	logic [NEVT-1:0] evt_sync;
	logic [NEVT-1:0] evt_prev_q;
	logic [NEVT-1:0] evt_pulse;

	assign evt_raw = {serial_b_evt, tmr_c_cmpa_evt, tmr_c_cmpp_evt,
	                  serial_a_evt, tmr_b_cmpa_evt, tmr_b_cmpp_evt,
	                  tmr_a_cmpa_evt, tmr_a_cmpp_evt};

	mfib_sync #(
		.WIDTH (NEVT)
	) u_evt_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in (evt_raw),
		.sync_out (evt_sync)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_prev_q <= '0;
		end else if (clk_en) begin
			evt_prev_q <= evt_sync;
		end
	end

	// one set pulse per rising edge of a source condition
	assign evt_pulse = evt_sync & ~evt_prev_q;

	// ----------------------------------------------------------------
	// register bank
	// ----------------------------------------------------------------
	mfib_byte_t   reg_val [`MFIB_NUM_REGS];
	logic [2:0]   reg_set [`MFIB_NUM_REGS];
	logic [`MFIB_NUM_REGS-1:0] reg_rise;

	// set vector order per register: {serial, cmpa, cmpp}
	assign reg_set[0] = {1'b0, evt_pulse[1], evt_pulse[0]}; // see R01, R02
	assign reg_set[1] = {evt_pulse[4], evt_pulse[3], evt_pulse[2]}; // see R04, R06, R07
	assign reg_set[2] = {evt_pulse[7], evt_pulse[6], evt_pulse[5]}; // see R10, R12, R13

	genvar gi;
	generate
		for (gi = 0; gi < `MFIB_NUM_REGS; gi++) begin : g_reg
			localparam mfib_byte_t MASK = (gi == 0) ? `MFIB_MASK_TMR : `MFIB_MASK_SER;
			mfib_flag_reg #(
				.IMPL_MASK (MASK)
			) u_reg (
				.clk       (clk),
				.reset_n   (reset_n),
				.clk_en    (clk_en),
				.wr_en     (reg_wr && !reg_rd && (reg_addr == mfib_addr_t'(gi))), // see R03, R05, R08, R09
				.wr_data   (reg_wdata),
				.set_pulse (reg_set[gi]),
				.value     (reg_val[gi]),
				.req       (mf_req[gi]), // see R11, R14, R15
				.flag_rise (reg_rise[gi])
			);
		end
	endgenerate

	// master enable gates the combined request toward the core
	assign mf_irq = global_irq_en & (|mf_req); // see R18

	// ----------------------------------------------------------------
	// low-power wake-up
	// ----------------------------------------------------------------
	mfib_pwr_t pwr_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pwr_q <= MFIB_ST_RUN;
		end else if (clk_en) begin
			case (pwr_q)
				MFIB_ST_RUN: begin
					if (sleep_req) pwr_q <= MFIB_ST_LOWPWR;
				end
				MFIB_ST_LOWPWR: begin
					if (|reg_rise) pwr_q <= MFIB_ST_RUN; // see R19
				end
				default: pwr_q <= MFIB_ST_RUN;
			endcase
		end
	end

	// already-set flags cannot rise again, so they do not wake
	assign wake = (pwr_q == MFIB_ST_LOWPWR) && (|reg_rise); // see R19

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `MFIB_RESET_VAL;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					`MFIB_OFS_TMR_A:     reg_rdata <= reg_val[0];
					`MFIB_OFS_SER0_TMRB: reg_rdata <= reg_val[1];
					`MFIB_OFS_SER1_TMRC: reg_rdata <= reg_val[2];
					`MFIB_OFS_WAKE:      reg_rdata <= {7'h00, pwr_q == MFIB_ST_LOWPWR};
					default:             reg_rdata <= `MFIB_RESET_VAL;
				endcase
			end else begin
				reg_rdata <= `MFIB_RESET_VAL;
			end
		end
	end
endmodule

//--- logic/mfib_regs.svh
// register offsets, field positions and reset values of the interrupt flag bank
// assumes: included by bare name from package and modules
`ifndef MFIB_REGS_SVH
`define MFIB_REGS_SVH

`define MFIB_ADDR_W        2
`define MFIB_OFS_TMR_A     2'h0
`define MFIB_OFS_SER0_TMRB 2'h1
`define MFIB_OFS_SER1_TMRC 2'h2
`define MFIB_OFS_WAKE      2'h3

`define MFIB_BIT_SER_F     6
`define MFIB_BIT_CMPA_F    5
`define MFIB_BIT_CMPP_F    4
`define MFIB_BIT_SER_E     2
`define MFIB_BIT_CMPA_E    1
`define MFIB_BIT_CMPP_E    0

`define MFIB_MASK_TMR      8'h33
`define MFIB_MASK_SER      8'h77
`define MFIB_RESET_VAL     8'h00
`define MFIB_NUM_REGS      3

`endif

//--- logic/mfib_pkg.sv
// types shared by the interrupt flag bank modules
// assumes: mfib_regs.svh on the include path
`include "mfib_regs.svh"
package mfib_pkg;
	typedef logic [7:0]               mfib_byte_t;
	typedef logic [`MFIB_ADDR_W-1:0]  mfib_addr_t;
	typedef enum logic [1:0] {
		MFIB_ST_RUN,
		MFIB_ST_LOWPWR
	} mfib_pwr_t;
endpackage

//--- logic/mfib_sync.sv
// two flip-flop synchroniser for event inputs coming from outside the clock domain
// assumes: clk, asynchronous active-low reset, clock enable
`timescale 1ns/100ps
module mfib_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

//--- logic/mfib_flag_reg.sv
// one 8-bit flag/enable register with hardware set, software write and request output
// assumes: set_pulse already synchronous to clk; mask selects implemented bits
`timescale 1ns/100ps
`include "mfib_regs.svh"
module mfib_flag_reg
	import mfib_pkg::*;
#(
	parameter mfib_byte_t IMPL_MASK = `MFIB_MASK_TMR
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       wr_en,
	input  wire mfib_byte_t wr_data,
	input  wire logic [2:0] set_pulse,
	output mfib_byte_t      value,
	output logic            req,
	output logic            flag_rise
);
	logic [2:0] set_vec;
	mfib_byte_t reg_q;
	mfib_byte_t reg_d;

	// set positions: cmpp, cmpa, serial flag
	assign set_vec = set_pulse & {IMPL_MASK[`MFIB_BIT_SER_F], IMPL_MASK[`MFIB_BIT_CMPA_F], IMPL_MASK[`MFIB_BIT_CMPP_F]};

	always_comb begin
		reg_d = reg_q;
		if (wr_en) begin
			reg_d = wr_data & IMPL_MASK; // see R16
		end
		// hardware set wins over a software clear, enable not consulted
		if (set_vec[0]) reg_d[`MFIB_BIT_CMPP_F] = 1'b1; // see R17
		if (set_vec[1]) reg_d[`MFIB_BIT_CMPA_F] = 1'b1; // see R17
		if (set_vec[2]) reg_d[`MFIB_BIT_SER_F]  = 1'b1; // see R17
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_q <= `MFIB_RESET_VAL;
		end else if (clk_en) begin
			reg_q <= reg_d;
		end
	end

	assign value = reg_q & IMPL_MASK; // see R16
	// flag nibble [6:4] gated by enable nibble [2:0]
	assign req = |(reg_q[6:4] & reg_q[2:0] & IMPL_MASK[6:4]); // see R20
	assign flag_rise = clk_en & |(reg_d[6:4] & ~reg_q[6:4] & IMPL_MASK[6:4]);
endmodule

//--- sim/mfib_checker.sv
// port checks for the interrupt flag bank
// assumes: bound into mfib_top, clk_en held high
`timescale 1ns/100ps
module mfib_checker
	import mfib_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire mfib_pkg::mfib_addr_t reg_addr,
	input wire mfib_pkg::mfib_byte_t reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire mfib_pkg::mfib_byte_t reg_rdata,
	input wire logic                 global_irq_en,
	input wire logic                 sleep_req,
	input wire logic [2:0]           mf_req,
	input wire logic                 mf_irq,
	input wire logic                 wake
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_wr(a, d);
		reg_wr && !reg_rd && reg_addr == a && (reg_wdata & ((reg_addr == 2'h0) ? 8'h33 : 8'h77)) == d;
	endsequence
	a_irq_gated: assert property (mf_irq == (global_irq_en && |mf_req)) else $error("irq gating");
	a_unimpl_tmr: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0 |-> (reg_rdata & 8'hcc) == 8'h00)
		else $error("reg0 spare bits");
	a_unimpl_ser: assert property ($past(reg_rd) && $past(reg_addr) inside {2'h1, 2'h2} |-> !reg_rdata[7] && !reg_rdata[3])
		else $error("ser spare bits");
	a_req_set_a: assert property (s_wr(2'h0, 8'h33) |=> mf_req[0]) else $error("req0 not set");
	a_req_set_b: assert property (s_wr(2'h1, 8'h77) |=> mf_req[1]) else $error("req1 not set");
	a_req_set_c: assert property (s_wr(2'h2, 8'h77) |=> mf_req[2]) else $error("req2 not set");
	a_req_clear: assert property (s_wr(2'h0, 8'h00) |=> !mf_req[0]) else $error("req0 not cleared");
	a_req_hold: assert property ($fell(mf_req[0]) |-> $past(reg_wr) && $past(reg_addr) == 2'h0)
		else $error("req0 dropped");
	a_wake_single: assert property (wake && !sleep_req |=> !wake) else $error("wake too long");
endmodule
bind mfib_top mfib_checker u_chk (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.global_irq_en, .sleep_req, .mf_req, .mf_irq, .wake);

//--- sim/mfib_src_model.sv
// timer and serial event sources
// assumes: events are sampled by synchronisers
`timescale 1ns/100ps
module mfib_src_model (
	input  wire logic clk,
	output logic [7:0] evt
);
	initial evt = 8'h00;
	// pulse long enough for two sync flops
	task automatic fire(input logic [7:0] m);
		@(posedge clk);
		evt <= m;
		repeat (2) @(posedge clk);
		evt <= 8'h00;
	endtask
endmodule

//--- sim/mfib_tb_top.sv
// self-checking bench for the interrupt flag bank
// assumes: mfib_src_model drives events, clk_en held high
`timescale 1ns/100ps
module mfib_tb_top;
	import mfib_pkg::*;
	logic                 clk, reset_n, reg_wr, reg_rd, global_irq_en, sleep_req, mf_irq, wake, wake_seen;
	mfib_pkg::mfib_addr_t reg_addr;
	mfib_pkg::mfib_byte_t reg_wdata, reg_rdata, v;
	logic [2:0]           mf_req;
	logic [7:0]           evt;
	int                   fail_count = 0;
	int                   total_checks = 0;
	mfib_src_model SRC (.clk, .evt);
	mfib_top DUT (.clk, .reset_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.global_irq_en, .tmr_a_cmpa_evt(evt[0]), .tmr_a_cmpp_evt(evt[1]), .tmr_b_cmpa_evt(evt[2]),
		.tmr_b_cmpp_evt(evt[3]), .tmr_c_cmpa_evt(evt[4]), .tmr_c_cmpp_evt(evt[5]), .serial_a_evt(evt[6]),
		.serial_b_evt(evt[7]), .sleep_req, .mf_req, .mf_irq, .wake);
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (wake === 1'b1) wake_seen <= 1;
	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	task automatic t_rw();
		for (int i = 0; i < 3; i++) begin
			rd(2'(i));
			chk(v, 8'h00);
			wr(2'(i), 8'hff);
			rd(2'(i));
			chk(v, i == 0 ? 8'h33 : 8'h77);
			@(posedge clk);
			#1 chk(reg_rdata, 8'h00);
		end
		@(posedge clk);
		global_irq_en <= 1;
		#1 chk({5'h0, mf_req}, 8'h07);
		chk({7'h0, mf_irq}, 8'h01);
		@(posedge clk);
		global_irq_en <= 0;
		#1 chk({7'h0, mf_irq}, 8'h00);
	endtask
	task automatic t_pairs();
		logic [7:0] f;
		for (int r = 0; r < 3; r++)
			for (int k = 0; k < 3; k++) if (r > 0 || k < 2) begin
				f = (k == 2) ? 8'h40 : 8'h20 >> k;
				wr(2'(r), f | (8'h07 & ~(f >> 4)));
				#1 chk({7'h0, mf_req[r]}, 8'h00);
				wr(2'(r), f | (f >> 4));
				#1 chk({7'h0, mf_req[r]}, 8'h01);
				wr(2'(r), 8'h00);
			end
	endtask
	task automatic t_evt();
		for (int i = 0; i < 8; i++) begin
			SRC.fire(8'h01 << i);
			repeat (2) @(posedge clk);
			rd(2'(i < 2 ? 0 : i < 6 ? i / 2 : i - 5));
			chk(v, i > 5 ? 8'h40 : 8'h20 >> (i % 2));
			chk({5'h0, mf_req}, 8'h00);
			wr(2'(i < 2 ? 0 : i < 6 ? i / 2 : i - 5), 8'h00);
		end
	endtask
	task automatic t_wake(input logic [7:0] exp);
		@(posedge clk);
		sleep_req <= 1;
		wake_seen <= 0;
		@(posedge clk);
		sleep_req <= 0;
		SRC.fire(8'h01);
		repeat (3) @(posedge clk);
		chk({7'h0, wake_seen}, exp);
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		summarize();
	end
	initial begin
		{reset_n, reg_wr, reg_rd, global_irq_en, sleep_req, wake_seen} = 6'h00;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		repeat (5) @(posedge clk);
		reset_n <= 1;
		t_rw();
		t_pairs();
		t_evt();
		t_wake(8'h01);
		t_wake(8'h00);
		rd(2'h3);
		chk(v, 8'h01);
		summarize();
	end
endmodule
